// ==== src/link_upper_pkg.sv ====
// constants and carrier types for the link status upper fields block
package link_upper_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] INPUTS_OFS = 12'h008;

   // ---------------------------------------------------------------
   // control register field positions
   // ---------------------------------------------------------------
   localparam int TX_PAUSE_POS = 0;
   localparam int RX_PAUSE_POS = 1;
   localparam int OEM_OK_POS   = 2;
   localparam int MOD_EN_POS   = 3;
   localparam int REV_NEW_POS  = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // ---------------------------------------------------------------
   // positions inside the status word (bits 15 to 23)
   // ---------------------------------------------------------------
   localparam int FIELD_LSB   = 15;
   localparam int FIELD_W     = 9;
   localparam logic [8:0] FIELD_RESET = 9'h000;
   localparam logic [1:0] MOD_NRZ  = 2'h1;
   localparam logic [1:0] MOD_PAM4 = 2'h2;
   localparam logic [1:0] MOD_NONE = 2'h0;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   localparam int LINK_IN_W = 8;
   localparam logic [7:0] LINK_IN_RESET = 8'h00;

   typedef struct packed {
      logic       serdes_on;
      logic       serdes_direct;
      logic       an_enable;
      logic       an_complete;
      logic       partner_10m_half_capable;
      logic [1:0] partner_pause;
      logic       pam4_active;
   } link_in_s;

   typedef struct packed {
      logic [8:7] modulation;
      logic       oem_valid;
      logic       direct_attach;
      logic [4:3] partner_pause;
      logic       rx_pause;
      logic       tx_pause;
      logic       partner_10m_half;
   } upper_field_s;

endpackage

// ==== src/link_status_upper_fields.sv ====
// link status upper fields: apb control plus composition of bits 15 to 23
`timescale 1ns/1ns
// Summary of operation
// RULE1 - bit15 reports partner 10M half capability
// RULE2 - bit16 shows pause transmit enable
// RULE3 - bit17 shows pause receive enable
// RULE4 - bits19:18 encode partner pause ability
// RULE5 - bit20 set for serdes direct attach
// RULE6 - bit21 set only when oem settings valid
// RULE7 - bits23:22 give nrz or pam4, never 11
// RULE8 - modulation zero for earlier protocol revisions
// RULE9 - invalid partner bits forced to zero

// ---------------------------------------------------------------
// three stage input filter
// ---------------------------------------------------------------
module sync3_filter #(
   parameter int W = 1
) (
   input  wire logic         i_clock,
   input  wire logic         i_rstn,
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;

   // shift chain; ff1 feeds only ff2
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
      end else if (i_en) begin
         ff1 <= i_d;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // accept a change once two later stages agree, rejects one-cycle glitches
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_q <= '0;
      end else if (i_en && (ff2 == ff3)) begin
         o_q <= ff3;
      end
   end
endmodule

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module link_status_upper_fields
   import link_upper_pkg::*;
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_RSTN,
   input  wire logic        I_CLK_EN,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   input  wire logic [3:0]  I_PSTRB,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_SERDES_ON,
   input  wire logic        I_SERDES_DIRECT,
   input  wire logic        I_AN_ENABLE,
   input  wire logic        I_AN_COMPLETE,
   input  wire logic        I_PARTNER_10M_HALF_CAPABLE,
   input  wire logic [1:0]  I_PARTNER_PAUSE,
   input  wire logic        I_PAM4_ACTIVE,
   output logic      [8:0]  O_UPPER_FIELDS
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   link_in_s     link_in;
   logic [7:0]   link_raw;
   logic [7:0]   link_q;
   logic [4:0]   ctrl;
   upper_field_s next_field;
   upper_field_s field;
   logic         partner_valid;
   logic         mod_on;
   logic         loaded;
   logic         mapped;
   logic         apb_done;
   logic         ctrl_write;
   logic [31:0]  next_prdata;

   // ---------------------------------------------------------------
   // assertion clocking
   // ---------------------------------------------------------------
   // all checks run on the one clock and sleep through reset
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RSTN);

   // ---------------------------------------------------------------
   // input capture
   // ---------------------------------------------------------------
   // phy and mac state arrive asynchronously, so every bit is filtered
   assign link_raw = {I_SERDES_ON, I_SERDES_DIRECT, I_AN_ENABLE, I_AN_COMPLETE,
                      I_PARTNER_10M_HALF_CAPABLE, I_PARTNER_PAUSE, I_PAM4_ACTIVE};

   sync3_filter #(
      .W (LINK_IN_W)
   ) u_filter (
      .i_clock (I_CLOCK),
      .i_rstn  (I_RSTN),
      .i_en    (I_CLK_EN),
      .i_d     (link_raw),
      .o_q     (link_q)
   );

   assign link_in = link_q;

   // a low enable must leave every register of the block as it was
   freeze_hold_a: assert property (
      !I_CLK_EN |=> $stable(link_q) && $stable(ctrl) && $stable(field) && $stable(O_PRDATA) && $stable(loaded))
      else $error("state moved while clock enable low");
   cover_freeze: cover property (!I_CLK_EN ##1 I_CLK_EN);

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   // read data is loaded in an enabled cycle before pready is given
   assign mapped     = (I_PADDR == CTRL_OFS) || (I_PADDR == STATUS_OFS) || (I_PADDR == INPUTS_OFS);
   assign O_PREADY   = I_CLK_EN & I_PSEL & I_PENABLE & loaded;
   assign O_PSLVERR  = O_PREADY & ~mapped;
   assign apb_done   = O_PREADY;
   assign ctrl_write = apb_done & I_PWRITE & I_PSTRB[0] & (I_PADDR == CTRL_OFS);

   // read mux; status and input words are read only
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (I_PADDR)
         CTRL_OFS: begin
            next_prdata[4:0] = ctrl;
         end
         STATUS_OFS: begin
            next_prdata[FIELD_LSB +: FIELD_W] = field;
         end
         INPUTS_OFS: begin
            next_prdata[7:0] = link_q;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // loaded marks that read data of the current transfer is in place
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         loaded <= 1'b0;
      end else if (I_CLK_EN) begin
         loaded <= I_PSEL & ~apb_done;
      end
   end

   // read data register, captured once per transfer
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PRDATA <= 32'h0000_0000;
      end else if (I_CLK_EN && I_PSEL && !loaded) begin
         O_PRDATA <= next_prdata;
      end
   end

   // control register, byte lane 0 only
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ctrl <= CTRL_RESET;
      end else if (ctrl_write) begin
         ctrl <= I_PWDATA[4:0];
      end
   end

   // ---------------------------------------------------------------
   // apb protocol checks
   // ---------------------------------------------------------------
   // a transfer answers for exactly one cycle, then waits for the next setup
   pready_pulse_a: assert property (
      O_PREADY |=> !O_PREADY)
      else $error("pready held for more than one cycle");

   // control read back shows the register as it stands at the answer
   ctrl_readback_a: assert property (
      O_PREADY && !I_PWRITE && I_PADDR == CTRL_OFS |-> O_PRDATA == {27'h000_0000, ctrl})
      else $error("control read data wrong");

   // an unmapped read returns zero alongside the error
   unmapped_zero_a: assert property (
      O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0000_0000)
      else $error("unmapped read data not zero");

   // a write with lane 0 set lands in control on the answering edge
   ctrl_land_a: assert property (
      ctrl_write |=> ctrl == $past(I_PWDATA[4:0]))
      else $error("control write lost");

   // refused writes: lane 0 off or another address leaves control alone
   strobe_refuse_a: assert property (
      O_PREADY && I_PWRITE && (!I_PSTRB[0] || I_PADDR != CTRL_OFS) |=> $stable(ctrl))
      else $error("control changed by a refused write");

   // ---------------------------------------------------------------
   // field composition
   // ---------------------------------------------------------------
   // partner advertisement only means something after copper autoneg
   assign partner_valid = ~link_in.serdes_on & link_in.an_enable & link_in.an_complete;
   // older revisions keep the modulation bits reserved
   assign mod_on = ctrl[MOD_EN_POS] & ctrl[REV_NEW_POS];

   always_comb begin
      next_field                  = FIELD_RESET;
      next_field.partner_10m_half = partner_valid & link_in.partner_10m_half_capable;  // [RULE1] [RULE9]
      next_field.tx_pause         = ctrl[TX_PAUSE_POS];                                 // [RULE2]
      next_field.rx_pause         = ctrl[RX_PAUSE_POS];                                 // [RULE3]
      next_field.partner_pause    = partner_valid ? link_in.partner_pause : 2'h0;       // [RULE4] [RULE9]
      next_field.direct_attach    = link_in.serdes_on & link_in.serdes_direct;          // [RULE5]
      next_field.oem_valid        = ctrl[OEM_OK_POS];                                   // [RULE6]
      if (mod_on) begin
         next_field.modulation = link_in.pam4_active ? MOD_PAM4 : MOD_NRZ;             // [RULE7]
      end else begin
         next_field.modulation = MOD_NONE;                                             // [RULE8]
      end
   end

   // registered word keeps the sideband reply stable for a whole cycle
   always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         field <= FIELD_RESET;
      end else if (I_CLK_EN) begin
         field <= next_field;
      end
   end

   assign O_UPPER_FIELDS = field;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   partner_10m_a: assert property ( // [RULE1]
      I_CLK_EN |=> O_UPPER_FIELDS[0] == $past(partner_valid & link_in.partner_10m_half_capable))
      else $error("partner 10M half bit wrong");

   tx_pause_a: assert property ( // [RULE2]
      ctrl_write |=> ##1 (!$past(I_CLK_EN) || O_UPPER_FIELDS[1] == $past(I_PWDATA[TX_PAUSE_POS], 2)))
      else $error("tx pause bit does not follow control");

   rx_pause_a: assert property ( // [RULE3]
      I_CLK_EN |=> O_UPPER_FIELDS[2] == $past(ctrl[RX_PAUSE_POS]))
      else $error("rx pause bit does not follow control");

   partner_pause_a: assert property ( // [RULE4]
      I_CLK_EN && partner_valid |=> O_UPPER_FIELDS[4:3] == $past(link_in.partner_pause))
      else $error("partner pause field wrong");

   direct_attach_a: assert property ( // [RULE5]
      I_CLK_EN && !link_in.serdes_on |=> !O_UPPER_FIELDS[5])
      else $error("direct attach set without serdes");

   oem_valid_a: assert property ( // [RULE6]
      I_CLK_EN |=> O_UPPER_FIELDS[6] == $past(ctrl[OEM_OK_POS]))
      else $error("oem valid bit wrong");

   mod_code_a: assert property ( // [RULE7]
      I_CLK_EN && mod_on |=> O_UPPER_FIELDS[8:7] == ($past(link_in.pam4_active) ? MOD_PAM4 : MOD_NRZ))
      else $error("modulation code wrong");

   mod_reserved_a: assert property ( // [RULE8]
      I_CLK_EN && !ctrl[REV_NEW_POS] |=> O_UPPER_FIELDS[8:7] == MOD_NONE)
      else $error("modulation driven on old revision");

   stale_zero_a: assert property ( // [RULE9]
      I_CLK_EN && !partner_valid |=> O_UPPER_FIELDS[0] == 1'b0 && O_UPPER_FIELDS[4:3] == 2'h0)
      else $error("stale partner bits shown");

   // every enabled cycle, not only after a write, the flag tracks control
   tx_follow_a: assert property ( // [RULE2]
      I_CLK_EN |=> O_UPPER_FIELDS[1] == $past(ctrl[TX_PAUSE_POS]))
      else $error("tx pause bit drifted from control");

   direct_set_a: assert property ( // [RULE5]
      I_CLK_EN && link_in.serdes_on && link_in.serdes_direct |=> O_UPPER_FIELDS[5])
      else $error("direct attach missing with serdes direct");

   mod_legal_a: assert property ( // [RULE7]
      O_UPPER_FIELDS[8:7] != 2'h3)
      else $error("reserved modulation code 11 shown");

   cover_partner: cover property (I_CLK_EN && partner_valid ##1 O_UPPER_FIELDS[4:3] == 2'h3);
   cover_pam4: cover property (O_UPPER_FIELDS[8:7] == MOD_PAM4);
   cover_write: cover property (ctrl_write ##1 ctrl[MOD_EN_POS]);
   cover_slverr: cover property (O_PSLVERR);

endmodule

// ==== test/link_phy_model.sv ====
// behavioural phy and mac state source feeding the link inputs
`timescale 1ns/1ns
module link_phy_model
   import link_upper_pkg::*;
(
   input  wire logic     i_clock,
   input  wire logic     i_rstn,
   input  wire link_in_s i_cfg,
   output link_in_s      o_pins
);
   // -------------------------------------------------------------
   // pin drive
   // -------------------------------------------------------------
   // the phy changes its levels only after a clock edge, never mid-cycle
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pins <= link_in_s'(LINK_IN_RESET);
      end else begin
         o_pins <= i_cfg;
      end
   end
endmodule

// ==== test/link_status_upper_fields_tb.sv ====
// self-checking bench for the link status upper fields block
`timescale 1ns/1ns
module link_status_upper_fields_tb
   import link_upper_pkg::*;
;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [8:0]  fields;
   link_in_s    cfg = link_in_s'(LINK_IN_RESET);
   link_in_s    pins;
   int          failures = 0;
   int          samples_checked = 0;
   logic [31:0] rd;
   logic        err;

   initial forever #5 clk = ~clk;

   link_phy_model i_phy (.i_clock(clk), .i_rstn(rstn), .i_cfg(cfg), .o_pins(pins));

   link_status_upper_fields i_dut (
      .I_CLOCK(clk), .I_RSTN(rstn), .I_CLK_EN(clk_en), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SERDES_ON(pins.serdes_on),
      .I_SERDES_DIRECT(pins.serdes_direct), .I_AN_ENABLE(pins.an_enable), .I_AN_COMPLETE(pins.an_complete),
      .I_PARTNER_10M_HALF_CAPABLE(pins.partner_10m_half_capable), .I_PARTNER_PAUSE(pins.partner_pause),
      .I_PAM4_ACTIVE(pins.pam4_active), .O_UPPER_FIELDS(fields));

   // -------------------------------------------------------------
   // verdict
   // -------------------------------------------------------------
   task automatic close_out();
      $display("checked %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask

   // -------------------------------------------------------------
   // apb master: request held until pready is sampled high
   // -------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         close_out();
      end
   endtask

   // expected field word worked out from the link levels and control bits
   function automatic logic [8:0] expect_fields(input link_in_s l, input logic [4:0] c);
      logic       ok;
      logic [8:0] e;
      ok = !l.serdes_on && l.an_enable && l.an_complete;
      e = 9'h000;
      e[0] = ok & l.partner_10m_half_capable;
      e[1] = c[0];
      e[2] = c[1];
      e[4:3] = ok ? l.partner_pause : 2'h0;
      e[5] = l.serdes_on & l.serdes_direct;
      e[6] = c[2];
      e[8:7] = (c[3] && c[4]) ? (l.pam4_active ? 2'h2 : 2'h1) : 2'h0;
      return e;
   endfunction

   // one setting: drive the pins, program control, let the filter settle, compare
   task automatic run_case(input int id, input logic [7:0] l, input logic [4:0] c);
      logic [8:0] e;
      cfg <= link_in_s'(l);
      apb(1'b1, CTRL_OFS, {27'h0, c}, 4'hf);
      e = expect_fields(link_in_s'(l), c);
      repeat (10) @(posedge clk);
      chk("fields port", {23'h0, e}, {23'h0, fields});
      apb(1'b0, STATUS_OFS, 32'h0, 4'h0);
      chk("status word", {8'h0, e, 15'h0}, rd);
      chk("status error", 32'h0, {31'h0, err});
      apb(1'b0, INPUTS_OFS, 32'h0, 4'h0);
      chk("inputs word", {24'h0, l}, rd);
      $display("test %0d done", id);
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      chk("fields at reset", 32'h0, {23'h0, fields});
      apb(1'b0, CTRL_OFS, 32'h0, 4'h0);
      chk("ctrl reset", {27'h0, CTRL_RESET}, rd);
      $display("test 0 done");
      // link bits: serdes_on direct an_en an_done p10 pause[1:0] pam4
      run_case(1, 8'b0011_1010, 5'h03);
      run_case(2, 8'b0011_0100, 5'h18);
      run_case(3, 8'b0011_1111, 5'h1c);
      run_case(4, 8'b1111_1111, 5'h08);
      run_case(5, 8'b0110_1110, 5'h01);
      run_case(6, 8'b0001_1110, 5'h12);
      run_case(7, 8'b0011_0000, 5'h00);
      // frozen enable: new pin levels must not reach the field word
      clk_en <= 1'b0;
      cfg <= link_in_s'(8'b0011_1010);
      repeat (10) @(posedge clk);
      chk("frozen fields", 32'h0, {23'h0, fields});
      clk_en <= 1'b1;
      repeat (10) @(posedge clk);
      chk("thawed fields", {23'h0, expect_fields(link_in_s'(8'b0011_1010), 5'h00)}, {23'h0, fields});
      $display("test 8 done");
      // refused accesses leave the control word alone
      apb(1'b1, CTRL_OFS, 32'h0000_0007, 4'h0);
      apb(1'b1, STATUS_OFS, 32'hffff_ffff, 4'hf);
      apb(1'b0, CTRL_OFS, 32'h0, 4'h0);
      chk("ctrl after refused writes", 32'h0, rd);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test 9 done");
      // reset in mid-run: control and field word return to reset values
      apb(1'b1, CTRL_OFS, 32'h0000_001f, 4'hf);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("fields in reset", 32'h0, {23'h0, fields});
      rstn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0, 4'h0);
      chk("ctrl after reset", {27'h0, CTRL_RESET}, rd);
      $display("test 10 done");
      close_out();
   end
endmodule
